/* File: logic/netset_pkg.sv */
// Shared constants and types for the push-button network setup block
`default_nettype none
package netset_pkg;
  // Clock and time base
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int FAST_MS     = 100;
  localparam int SLOW_MS     = 500;
  localparam int GAP_MS      = 1000;
  localparam int PAUSE_MS    = 1000;
  localparam int TIMEOUT_MS  = 60000;
  localparam logic [3:0] FAST_TICKS = 4'(FAST_MS / TICK_MS);
  localparam logic [3:0] SLOW_TICKS = 4'(SLOW_MS / TICK_MS);
  localparam logic [3:0] SEC_TICKS  = 4'(GAP_MS / TICK_MS);
  localparam logic [3:0] PAUSE_TICKS = 4'(PAUSE_MS / TICK_MS);
  localparam logic [9:0] TIMEOUT_TICKS = 10'(TIMEOUT_MS / TICK_MS);

  // Press-count commands
  localparam logic [2:0] PRESS_READOUT = 3'h3;
  localparam logic [2:0] PRESS_CHANGE  = 3'h5;

  // Step limits
  localparam logic [7:0] TENS_MAX  = 8'h0C;
  localparam logic [7:0] UNITS_MAX = 8'h09;
  localparam logic [7:0] TEN       = 8'h0A;

  // Fieldbus kinds and their highest baud index
  localparam logic [2:0] BUS_PROP   = 3'h0;
  localparam logic [2:0] BUS_MODBUS = 3'h1;
  localparam logic [2:0] BUS_PROFI  = 3'h2;
  localparam logic [2:0] BUS_CAN    = 3'h3;
  localparam logic [2:0] BUS_DNET   = 3'h4;
  localparam logic [2:0] BUS_ETH    = 3'h5;
  localparam logic [7:0] BAUD_MAX_PROP   = 8'h02;
  localparam logic [7:0] BAUD_MAX_MODBUS = 8'h08;
  localparam logic [7:0] BAUD_MAX_PROFI  = 8'h0A;
  localparam logic [7:0] BAUD_MAX_CAN    = 8'h08;
  localparam logic [7:0] BAUD_MAX_DNET   = 8'h03;
  localparam logic [7:0] BAUD_MAX_ETH    = 8'h01;

  // Register map
  localparam logic [7:0] CFG_OFF  = 8'h00;
  localparam logic [7:0] STAT_OFF = 8'h04;
  localparam int CFG_NODE_LSB = 0;
  localparam int CFG_BAUD_LSB = 8;
  localparam int CFG_BUS_LSB  = 12;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_PHASE_LSB = 4;
  localparam int STAT_BTN_LSB   = 6;
  localparam int STAT_PCNT_LSB  = 8;
  localparam logic [7:0] NODE_RST = 8'h03;
  localparam logic [3:0] BAUD_RST = 4'h1;
  localparam logic [2:0] BUS_RST  = 3'h1;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_SHOW = 4'h2,
    ST_WAIT = 4'h4,
    ST_HOLD = 4'h8
  } state_t;

  typedef struct packed {
    logic [2:0] bus;
    logic [3:0] baud;
    logic [7:0] node;
  } cfg_t;

  typedef struct packed {
    state_t      state;
    logic [2:0]  sync;
    logic        btn;
    logic [21:0] div;
    logic        tick;
    logic [2:0]  pcnt;
    logic [3:0]  gap;
    logic [3:0]  hold;
    logic [9:0]  idle;
    logic [3:0]  tcnt;
    logic        led_on;
    logic [1:0]  phase;
    logic [7:0]  cnt;
    logic [3:0]  sel_t;
    logic [3:0]  sel_u;
    cfg_t        cfg;
    logic [31:0] prdata;
  } st_t;

  function automatic logic [7:0] baud_max(input logic [2:0] bus);
    case (bus)
      BUS_PROP:   baud_max = BAUD_MAX_PROP;
      BUS_MODBUS: baud_max = BAUD_MAX_MODBUS;
      BUS_PROFI:  baud_max = BAUD_MAX_PROFI;
      BUS_CAN:    baud_max = BAUD_MAX_CAN;
      BUS_DNET:   baud_max = BAUD_MAX_DNET;
      default:    baud_max = BAUD_MAX_ETH;
    endcase
  endfunction
endpackage
`default_nettype wire

/* File: logic/netset_top.sv */
// One-button, two-LED node address and baud index readout and change
//
// The APB register port and the placing of the registers are this design's own decisions.
`default_nettype none
module netset_top #(
  parameter int TICK_CYCLES = netset_pkg::TICK_CYC
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_N_IN,
  input  wire logic        BUTTON_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic [31:0]      PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  output logic             LED_GREEN_OUT,
  output logic             LED_RED_OUT
);
  netset_pkg::st_t s_r;
  netset_pkg::st_t s_nxt;
  logic            press;
  logic            release_ev;
  logic            btn_new;
  logic            dec_fire;
  logic            short_hold;
  logic            hit_cfg;
  logic            hit_stat;
  logic [7:0]      step_max;
  logic [3:0]      pick;

  function automatic logic [7:0] tens_of(input logic [7:0] v);
    tens_of = v / netset_pkg::TEN;
  endfunction

  function automatic logic [7:0] units_of(input logic [7:0] v);
    units_of = v % netset_pkg::TEN;
  endfunction

  // Change counts once the second and third stage agree
  assign btn_new    = (s_r.sync[1] == s_r.sync[2]) ? s_r.sync[2] : s_r.btn;
  assign press      = btn_new & ~s_r.btn;
  assign release_ev = ~btn_new & s_r.btn;
  assign short_hold = s_r.hold < netset_pkg::SEC_TICKS;
  assign dec_fire   = (s_r.state == netset_pkg::ST_IDLE) && s_r.tick &&
                      !s_r.btn && s_r.pcnt != 3'h0 &&
                      s_r.gap >= netset_pkg::SEC_TICKS;
  assign hit_cfg    = PADDR_IN == netset_pkg::CFG_OFF;
  assign hit_stat   = PADDR_IN == netset_pkg::STAT_OFF;
  assign pick       = short_hold ? 4'h0 : s_r.cnt[3:0];

  always_comb
  begin
    unique case (s_r.phase)
      2'h0:    step_max = netset_pkg::TENS_MAX;
      2'h1:    step_max = netset_pkg::UNITS_MAX;
      default: step_max = netset_pkg::baud_max(s_r.cfg.bus);
    endcase
  end

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.sync = {s_r.sync[1:0], BUTTON_IN};
    s_nxt.btn  = btn_new;
    s_nxt.tick = 1'b0;
    if (s_r.div == 22'(TICK_CYCLES - 1))
    begin
      s_nxt.div  = 22'h000000;
      s_nxt.tick = 1'b1;
    end
    else
      s_nxt.div = s_r.div + 22'h000001;
    // Hold time in ticks, saturating so a long hold never wraps short
    if (press)
      s_nxt.hold = 4'h0;
    else if (s_r.btn && s_r.tick && short_hold)
      s_nxt.hold = s_r.hold + 4'h1;

    unique case (s_r.state)
      netset_pkg::ST_IDLE:
      begin
        s_nxt.led_on = 1'b0;
        if (press)
          s_nxt.gap = 4'h0;
        if (release_ev)
        begin
          s_nxt.gap = 4'h0;
          // A long hold belongs to other switch functions
          if (short_hold && s_r.pcnt != 3'h7)
            s_nxt.pcnt = s_r.pcnt + 3'h1;
          else if (!short_hold)
            s_nxt.pcnt = 3'h0;
        end
        else if (!s_r.btn && s_r.tick && s_r.pcnt != 3'h0)
          s_nxt.gap = s_r.gap + 4'h1;
        if (dec_fire)
        begin
          s_nxt.pcnt  = 3'h0;
          s_nxt.phase = 2'h0;
          if (s_r.pcnt == netset_pkg::PRESS_READOUT)
          begin
            s_nxt.state = netset_pkg::ST_SHOW;
            s_nxt.cnt   = tens_of(s_r.cfg.node);
            s_nxt.tcnt  = netset_pkg::PAUSE_TICKS - 4'h1;
          end
          else if (s_r.pcnt == netset_pkg::PRESS_CHANGE &&
                   s_r.cfg.bus != netset_pkg::BUS_ETH)
          begin
            s_nxt.state  = netset_pkg::ST_WAIT;
            s_nxt.idle   = 10'h000;
            s_nxt.tcnt   = netset_pkg::FAST_TICKS - 4'h1;
            s_nxt.led_on = 1'b1;
          end
        end
      end
      netset_pkg::ST_SHOW:
      begin
        if (s_r.tick)
        begin
          if (s_r.tcnt != 4'h0)
            s_nxt.tcnt = s_r.tcnt - 4'h1;
          else if (s_r.led_on)
          begin
            s_nxt.led_on = 1'b0;
            s_nxt.cnt    = s_r.cnt - 8'h01;
            s_nxt.tcnt   = netset_pkg::SLOW_TICKS - 4'h1;
          end
          else if (s_r.cnt != 8'h00)
          begin
            s_nxt.led_on = 1'b1;
            s_nxt.tcnt   = netset_pkg::SLOW_TICKS - 4'h1;
          end
          else if (s_r.phase == 2'h2)
            s_nxt.state = netset_pkg::ST_IDLE;
          else
          begin
            // Pause between steps keeps the digits apart for the eye
            s_nxt.phase = s_r.phase + 2'h1;
            s_nxt.tcnt  = netset_pkg::PAUSE_TICKS - 4'h1;
            s_nxt.cnt   = (s_r.phase == 2'h0) ?
                          units_of(s_r.cfg.node) :
                          {4'h0, s_r.cfg.baud};
          end
        end
      end
      netset_pkg::ST_WAIT:
      begin
        if (press)
        begin
          s_nxt.state  = netset_pkg::ST_HOLD;
          s_nxt.cnt    = 8'h00;
          s_nxt.led_on = 1'b0;
          s_nxt.tcnt   = netset_pkg::SLOW_TICKS - 4'h1;
        end
        else if (s_r.tick)
        begin
          s_nxt.idle = s_r.idle + 10'h001;
          if (s_r.idle == netset_pkg::TIMEOUT_TICKS - 10'h001)
            s_nxt.state = netset_pkg::ST_IDLE;
          if (s_r.tcnt != 4'h0)
            s_nxt.tcnt = s_r.tcnt - 4'h1;
          else
          begin
            s_nxt.led_on = ~s_r.led_on;
            s_nxt.tcnt   = netset_pkg::FAST_TICKS - 4'h1;
          end
        end
      end
      netset_pkg::ST_HOLD:
      begin
        if (release_ev)
        begin
          s_nxt.phase  = s_r.phase + 2'h1;
          s_nxt.state  = netset_pkg::ST_WAIT;
          s_nxt.idle   = 10'h000;
          s_nxt.led_on = 1'b1;
          s_nxt.tcnt   = netset_pkg::FAST_TICKS - 4'h1;
          unique case (s_r.phase)
            2'h0: s_nxt.sel_t = pick;
            2'h1: s_nxt.sel_u = pick;
            default:
            begin
              s_nxt.state     = netset_pkg::ST_IDLE;
              s_nxt.phase     = 2'h0;
              s_nxt.cfg.node  = 8'(s_r.sel_t * netset_pkg::TEN) +
                                {4'h0, s_r.sel_u};
              s_nxt.cfg.baud  = pick;
            end
          endcase
        end
        else if (s_r.tick)
        begin
          if (s_r.tcnt != 4'h0)
            s_nxt.tcnt = s_r.tcnt - 4'h1;
          else
          begin
            s_nxt.led_on = ~s_r.led_on;
            s_nxt.tcnt   = netset_pkg::SLOW_TICKS - 4'h1;
            if (!s_r.led_on)
              s_nxt.cnt = (s_r.cnt >= step_max) ? 8'h01 :
                          s_r.cnt + 8'h01;
          end
        end
      end
    endcase

    // Register access; a menu commit in the same cycle wins
    if (PSEL_IN && PENABLE_IN && PWRITE_IN && hit_cfg &&
        !(s_r.state == netset_pkg::ST_HOLD && release_ev &&
          s_r.phase == 2'h2))
    begin
      s_nxt.cfg.node = PWDATA_IN[netset_pkg::CFG_NODE_LSB +: 8];
      s_nxt.cfg.baud = PWDATA_IN[netset_pkg::CFG_BAUD_LSB +: 4];
      s_nxt.cfg.bus  = PWDATA_IN[netset_pkg::CFG_BUS_LSB +: 3];
    end
    if (PSEL_IN && !PENABLE_IN)
    begin
      s_nxt.prdata = 32'h00000000;
      if (hit_cfg)
      begin
        s_nxt.prdata[netset_pkg::CFG_NODE_LSB +: 8] = s_r.cfg.node;
        s_nxt.prdata[netset_pkg::CFG_BAUD_LSB +: 4] = s_r.cfg.baud;
        s_nxt.prdata[netset_pkg::CFG_BUS_LSB +: 3]  = s_r.cfg.bus;
      end
      else if (hit_stat)
      begin
        s_nxt.prdata[netset_pkg::STAT_STATE_LSB +: 4] = s_r.state;
        s_nxt.prdata[netset_pkg::STAT_PHASE_LSB +: 2] = s_r.phase;
        s_nxt.prdata[netset_pkg::STAT_BTN_LSB]        = s_r.btn;
        s_nxt.prdata[netset_pkg::STAT_PCNT_LSB +: 3]  = s_r.pcnt;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN)
  begin
    if (!RESET_N_IN)
    begin
      s_r          <= '0;
      s_r.state    <= netset_pkg::ST_IDLE;
      s_r.cfg.node <= netset_pkg::NODE_RST;
      s_r.cfg.baud <= netset_pkg::BAUD_RST;
      s_r.cfg.bus  <= netset_pkg::BUS_RST;
    end
    else
      s_r <= s_nxt;
  end

  assign PRDATA_OUT    = s_r.prdata;
  assign PREADY_OUT    = PSEL_IN & PENABLE_IN;
  assign PSLVERR_OUT   = PSEL_IN & PENABLE_IN & ~(hit_cfg | hit_stat);
  assign LED_GREEN_OUT = s_r.led_on && s_r.state != netset_pkg::ST_IDLE &&
                         s_r.phase != 2'h1;
  assign LED_RED_OUT   = s_r.led_on && s_r.state != netset_pkg::ST_IDLE &&
                         s_r.phase != 2'h0;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  property p_readout_start;
    dec_fire && s_r.pcnt == netset_pkg::PRESS_READOUT |=>
      s_r.state == netset_pkg::ST_SHOW && s_r.phase == 2'h0 &&
      s_r.cnt == tens_of($past(s_r.cfg.node));
  endproperty
  a_readout_start: assert property (p_readout_start)
    else $error("readout did not start with tens count");

  property p_both_flash;
    s_r.state == netset_pkg::ST_SHOW && s_r.phase == 2'h2 |->
      LED_GREEN_OUT == LED_RED_OUT;
  endproperty
  a_both_flash: assert property (p_both_flash)
    else $error("baud step LEDs not together");

  property p_change_enter;
    dec_fire && s_r.pcnt == netset_pkg::PRESS_CHANGE |=>
      (s_r.state == netset_pkg::ST_WAIT) ==
      ($past(s_r.cfg.bus) != netset_pkg::BUS_ETH);
  endproperty
  a_change_enter: assert property (p_change_enter)
    else $error("change entry wrong for bus kind");

  property p_fast_flash;
    s_r.state == netset_pkg::ST_WAIT && s_r.tick && !press &&
      s_r.tcnt == 4'h0 |=> s_r.led_on != $past(s_r.led_on);
  endproperty
  a_fast_flash: assert property (p_fast_flash)
    else $error("fast flash did not toggle");

  property p_hold_max;
    s_r.state == netset_pkg::ST_HOLD |-> s_r.cnt <= step_max;
  endproperty
  a_hold_max: assert property (p_hold_max)
    else $error("held count above step maximum");

  sequence s_short_release;
    s_r.state == netset_pkg::ST_HOLD && release_ev && short_hold &&
      s_r.phase == 2'h0;
  endsequence
  property p_zero_pick;
    s_short_release |=> s_r.sel_t == 4'h0 &&
      s_r.state == netset_pkg::ST_WAIT && s_r.phase == 2'h1;
  endproperty
  a_zero_pick: assert property (p_zero_pick)
    else $error("short hold did not select zero");

  sequence s_long_release;
    s_r.state == netset_pkg::ST_HOLD && release_ev && !short_hold &&
      s_r.phase == 2'h1;
  endsequence
  property p_latch_units;
    s_long_release |=> s_r.sel_u == $past(s_r.cnt[3:0]);
  endproperty
  a_latch_units: assert property (p_latch_units)
    else $error("units not latched from flash count");

  property p_timeout;
    s_r.state == netset_pkg::ST_WAIT && s_r.tick && !press &&
      s_r.idle == netset_pkg::TIMEOUT_TICKS - 10'h001 |=>
      s_r.state == netset_pkg::ST_IDLE && $stable(s_r.cfg);
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout did not cancel");

  property p_commit_only_end;
    $changed(s_r.cfg) && !$past(PSEL_IN && PENABLE_IN && PWRITE_IN) |->
      $past(s_r.state) == netset_pkg::ST_HOLD && $past(s_r.phase) == 2'h2;
  endproperty
  a_commit_only_end: assert property (p_commit_only_end)
    else $error("configuration changed outside final step");

  property p_gap_decode;
    s_r.state == netset_pkg::ST_IDLE && s_r.pcnt != 3'h0 && !dec_fire
      && !release_ev |=> s_r.pcnt != 3'h0;
  endproperty
  a_gap_decode: assert property (p_gap_decode)
    else $error("press count lost before gap expired");
endmodule
`default_nettype wire

/* File: dv/netset_operator.sv */
// Behavioural push-button operator driving the block's button pin
`default_nettype none
module netset_operator #(
  parameter int TICK_CYCLES = 4
) (
  input  wire logic clk_in,
  output var logic  button_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial button_out = 1'b0;

  // Press for a number of ticks, then release
  task automatic hold(input int ticks);
    @(posedge clk_in);
    button_out <= 1'b1;
    repeat (ticks * TICK_CYCLES) @(posedge clk_in);
    button_out <= 1'b0;
  endtask

  task automatic rest(input int ticks);
    repeat (ticks * TICK_CYCLES) @(posedge clk_in);
  endtask

  // Short presses, gaps well under one second so the count keeps running
  task automatic taps(input int n);
    repeat (n)
    begin
      hold(2);
      rest(3);
    end
  endtask
endmodule
`default_nettype wire

/* File: dv/test_netset_top.sv */
// Self-checking bench for the button and LED network setup block
`default_nettype none
module test_netset_top;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int TC = 4;

  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        led_g;
  logic        led_r;
  logic        button;
  logic        pg;
  logic        pr;
  logic [31:0] rd;
  logic        err;
  int          num_errors;
  int          num_checks;
  int          ng;
  int          nr;
  int          nb;
  int          cyc;
  int          t0;

  netset_top #(.TICK_CYCLES(TC)) i_netset_top (
    .MCLK_IN       (clk),
    .RESET_N_IN    (rst_n),
    .BUTTON_IN     (button),
    .PSEL_IN       (psel),
    .PENABLE_IN    (penable),
    .PWRITE_IN     (pwrite),
    .PADDR_IN      (paddr),
    .PWDATA_IN     (pwdata),
    .PRDATA_OUT    (prdata),
    .PREADY_OUT    (pready),
    .PSLVERR_OUT   (pslverr),
    .LED_GREEN_OUT (led_g),
    .LED_RED_OUT   (led_r)
  );

  netset_operator #(.TICK_CYCLES(TC)) i_netset_operator (
    .clk_in     (clk),
    .button_out (button)
  );

  always #20 clk = ~clk;

  // Flash counter on the falling edge, where the LEDs have settled
  always @(negedge clk)
  begin
    cyc++;
    if (led_g === 1'b1 && led_r === 1'b1 && !(pg || pr))
      nb++;
    else if (led_g === 1'b1 && !pg && led_r === 1'b0)
      ng++;
    else if (led_r === 1'b1 && !pr && led_g === 1'b0)
      nr++;
    pg = (led_g === 1'b1);
    pr = (led_r === 1'b1);
  end

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      check("apb_ready", 32'h0, 32'h1);
      results();
    end
  endtask

  // Poll the state field with a bounded number of reads
  task automatic wait_state(input logic [3:0] s);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, netset_pkg::STAT_OFF, 32'h0);
      n++;
    end
    while (rd[3:0] !== s && n < 2000);
    if (n >= 2000)
    begin
      check("state_wait", {28'h0, rd[3:0]}, {28'h0, s});
      results();
    end
  endtask

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pg = 1'b0;
    pr = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;

    apb(1'b0, netset_pkg::CFG_OFF, 32'h0);
    check("cfg_reset", rd, 32'h0000_1103);
    apb(1'b1, 8'h08, 32'hFFFF_FFFF);
    check("unmapped_wr_err", {31'h0, err}, 32'h1);
    apb(1'b1, netset_pkg::STAT_OFF, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_rd_err", {31'h0, err}, 32'h1);
    check("unmapped_rd", rd, 32'h0);
    apb(1'b0, netset_pkg::STAT_OFF, 32'h0);
    check("stat_idle", {28'h0, rd[3:0]}, 32'h1);

    // Readout of node 116, baud index 2
    apb(1'b1, netset_pkg::CFG_OFF, 32'h0000_1274);
    ng = 0;
    nr = 0;
    nb = 0;
    i_netset_operator.taps(3);
    wait_state(netset_pkg::ST_SHOW);
    wait_state(netset_pkg::ST_IDLE);
    check("green_tens", ng, 32'd11);
    check("red_units", nr, 32'd6);
    check("both_baud", nb, 32'd2);

    // Change: tens wraps to 1, units 0, baud 3
    i_netset_operator.taps(5);
    wait_state(netset_pkg::ST_WAIT);
    check("phase_tens", {30'h0, rd[5:4]}, 32'h0);
    ng = 0;
    nr = 0;
    repeat (20 * TC) @(posedge clk);
    check("fast_green", 32'(ng >= 9 && ng <= 11), 32'h1);
    check("fast_red_off", nr, 32'd0);
    i_netset_operator.hold(130);
    wait_state(netset_pkg::ST_WAIT);
    check("phase_units", {30'h0, rd[5:4]}, 32'h1);
    i_netset_operator.hold(3);
    wait_state(netset_pkg::ST_WAIT);
    check("phase_baud", {30'h0, rd[5:4]}, 32'h2);
    // Clear the count once the press is seen, so fast flashes stay out
    fork
      i_netset_operator.hold(30);
      begin
        repeat (6) @(posedge clk);
        nb = 0;
      end
    join
    check("slow_both", nb, 32'd3);
    wait_state(netset_pkg::ST_IDLE);
    apb(1'b0, netset_pkg::CFG_OFF, 32'h0);
    check("cfg_changed", rd, 32'h0000_130A);

    // Timeout after the first step discards everything
    i_netset_operator.taps(5);
    wait_state(netset_pkg::ST_WAIT);
    i_netset_operator.hold(20);
    t0 = cyc;
    wait_state(netset_pkg::ST_IDLE);
    check("timeout_len",
          32'(cyc - t0 >= 600 * TC - 10 && cyc - t0 <= 600 * TC + 30),
          32'h1);
    apb(1'b0, netset_pkg::CFG_OFF, 32'h0);
    check("cfg_kept", rd, 32'h0000_130A);

    // Ethernet kind refuses the change state
    apb(1'b1, netset_pkg::CFG_OFF, 32'h0000_510A);
    i_netset_operator.taps(5);
    i_netset_operator.rest(15);
    apb(1'b0, netset_pkg::STAT_OFF, 32'h0);
    check("eth_refused", {28'h0, rd[3:0]}, 32'h1);
    check("eth_decoded", {29'h0, rd[10:8]}, 32'h0);

    // Reset in mid readout returns to idle with reset configuration
    i_netset_operator.taps(3);
    wait_state(netset_pkg::ST_SHOW);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("led_reset", {30'h0, led_g, led_r}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, netset_pkg::CFG_OFF, 32'h0);
    check("cfg_rst_again", rd, 32'h0000_1103);
    apb(1'b0, netset_pkg::STAT_OFF, 32'h0);
    check("stat_rst_again", {28'h0, rd[3:0]}, 32'h1);
    results();
  end
endmodule
`default_nettype wire
